// File: inc/cpt_pkg.sv
`default_nettype none
package cpt_pkg;

	// ********************************
	// register map (byte addresses)
	// ********************************
	localparam logic [4:0] PWR_CTRL_OFS = 5'h00;
	localparam logic [4:0] TX_GAIN_OFS = 5'h04;
	localparam logic [4:0] CONV_MODE_OFS = 5'h08;
	localparam logic [4:0] TX_WORD_OFS = 5'h0c;
	localparam logic [4:0] STATUS_OFS = 5'h10;

	// ********************************
	// field positions
	// ********************************
	localparam int PWR_UP_BIT = 0;
	localparam int EAR_DIFF_BIT = 1;
	localparam int EAR_MUTE_BIT = 3;
	localparam int MIC_MUTE_BIT = 6;
	localparam int SIDETONE_MUTE_BIT = 7;
	localparam int GAIN_OVR_BIT = 7;
	localparam int GAIN_MODE_BIT = 3;
	localparam int CONV_LINEAR_BIT = 0;
	localparam int CONV_ALAW_BIT = 1;
	localparam int ST_POWERED_BIT = 0;
	localparam int ST_MCLK_BIT = 1;
	localparam int ST_LINK_BUSY_BIT = 2;
	localparam int ST_PENDING_BIT = 3;
	localparam int ST_DEEP_PD_BIT = 4;

	// ********************************
	// reset values
	// ********************************
	localparam logic [7:0] PWR_CTRL_RST = 8'h00;
	localparam logic [7:0] TX_GAIN_RST = 8'h0b;
	localparam logic [1:0] CONV_MODE_RST = 2'h0;
	localparam logic [14:0] TX_WORD_RST = 15'h0000;

	// ********************************
	// word lengths and timing
	// ********************************
	localparam logic [3:0] LINEAR_LAST = 4'he;
	localparam logic [3:0] COMPAND_LAST = 4'h7;
	localparam int CLK_PERIOD_NS = 25;
	localparam int MCLK_LOSS_NS = 20000;
	localparam int MCLK_LOSS_CYC = MCLK_LOSS_NS / CLK_PERIOD_NS;
	localparam logic [9:0] MCLK_LOSS_CNT = 10'(MCLK_LOSS_CYC);

	typedef enum logic [1:0] {
		CPT_PS_DOWN = 2'b00,
		CPT_PS_UP = 2'b01,
		CPT_PS_DRAIN = 2'b11
	} cpt_pwr_e;

endpackage
`default_nettype wire

// File: rtl/cpt_codec_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_codec_ctrl import cpt_pkg::*; (
	// system
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// master clock pin
	input wire logic masterClock,
	// pcm link
	input wire logic pcmBitClock,
	input wire logic pcmFrameSync,
	output logic pcmSerialOut,
	output logic pcmSerialOutEn_n,
	// analog controls
	output logic powered,
	output logic deepPowerDown,
	output logic differentialEarphoneEn,
	output logic singleEndedEarphoneEn,
	output logic earphoneMute,
	output logic sidetoneMute,
	output logic microphoneMute,
	output logic [3:0] txGainCode,
	output logic extendedGainMode,
	output logic linearMode,
	output logic aLawMode
);

	// ********************************
	// register bus
	// ********************************
	function automatic logic [2:0] regIndex(input logic [4:0] a);
		return a[4:2];
	endfunction

	logic [7:0] pwrCtrl_ff;
	logic [7:0] txGain_ff;
	logic [1:0] convMode_ff;
	logic [14:0] txWord_ff;
	logic ack_ff;
	logic wrStb;
	logic rdStb;
	logic [31:0] nxt_readdata;
	logic mclkLost_ff;
	logic linkBusyS2_ff;
	logic pending;
	cpt_pwr_e pwrState_ff;

	// one wait state on every access
	assign waitrequest = (read | write) & ~ack_ff;
	assign wrStb = write & ~ack_ff;
	assign rdStb = read & ~ack_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (read | write) & ~ack_ff;
		end
	end

	// writes land whatever the power state
	always_ff @(posedge clk) begin
		if (rst) begin
			pwrCtrl_ff <= PWR_CTRL_RST;
			txGain_ff <= TX_GAIN_RST;
			convMode_ff <= CONV_MODE_RST;
		end else if (wrStb && byteenable[0]) begin
			case (regIndex(address))
				regIndex(PWR_CTRL_OFS): begin
					pwrCtrl_ff <= writedata[7:0];
				end
				regIndex(TX_GAIN_OFS): begin
					txGain_ff <= writedata[7:0];
				end
				regIndex(CONV_MODE_OFS): begin
					convMode_ff <= writedata[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		nxt_readdata = 32'h0000_0000;
		case (regIndex(address))
			regIndex(PWR_CTRL_OFS): begin
				nxt_readdata[7:0] = pwrCtrl_ff;
			end
			regIndex(TX_GAIN_OFS): begin
				nxt_readdata[7:0] = txGain_ff;
			end
			regIndex(CONV_MODE_OFS): begin
				nxt_readdata[1:0] = convMode_ff;
			end
			regIndex(TX_WORD_OFS): begin
				nxt_readdata[14:0] = txWord_ff;
			end
			regIndex(STATUS_OFS): begin
				nxt_readdata[ST_POWERED_BIT] = (pwrState_ff != CPT_PS_DOWN);
				nxt_readdata[ST_MCLK_BIT] = ~mclkLost_ff;
				nxt_readdata[ST_LINK_BUSY_BIT] = linkBusyS2_ff;
				nxt_readdata[ST_PENDING_BIT] = pending;
				nxt_readdata[ST_DEEP_PD_BIT] = deepPowerDown;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (rdStb) begin
			readdata <= nxt_readdata;
		end
	end

	// ********************************
	// transmit word handover to link
	// ********************************
	// a toggle handshake; the word stays frozen until the link acknowledges
	logic reqTgl_ff;
	logic ackS1_ff;
	logic ackS2_ff;
	logic ackTgl_ff;
	logic txLinear_ff;

	assign pending = reqTgl_ff ^ ackS2_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			txWord_ff <= TX_WORD_RST;
			txLinear_ff <= 1'b0;
			reqTgl_ff <= 1'b0;
		end else if (wrStb && byteenable[1:0] == 2'b11 && !pending &&
				regIndex(address) == regIndex(TX_WORD_OFS)) begin
			txWord_ff <= writedata[14:0];
			txLinear_ff <= convMode_ff[CONV_LINEAR_BIT];
			reqTgl_ff <= ~reqTgl_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ackS1_ff <= 1'b0;
			ackS2_ff <= 1'b0;
		end else begin
			ackS1_ff <= ackTgl_ff;
			ackS2_ff <= ackS1_ff;
		end
	end

	// ********************************
	// master clock detection
	// ********************************
	logic mclkS1_ff;
	logic mclkS2_ff;
	logic mclkS3_ff;
	logic [9:0] mclkIdle_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			mclkS1_ff <= 1'b0;
			mclkS2_ff <= 1'b0;
			mclkS3_ff <= 1'b0;
		end else begin
			mclkS1_ff <= masterClock;
			mclkS2_ff <= mclkS1_ff;
			mclkS3_ff <= mclkS2_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mclkIdle_ff <= 10'h000;
			mclkLost_ff <= 1'b0;
		end else if (mclkS2_ff ^ mclkS3_ff) begin
			mclkIdle_ff <= 10'h000;
			mclkLost_ff <= 1'b0;
		end else if (mclkIdle_ff == MCLK_LOSS_CNT) begin
			mclkLost_ff <= 1'b1;
		end else begin
			mclkIdle_ff <= mclkIdle_ff + 10'h001;
		end
	end

	// ********************************
	// power sequencing
	// ********************************
	logic linkBusyS1_ff;
	logic linkBusy_ff;
	logic overrideMclk;
	logic autoDown;

	// with the override set, clock loss neither blocks nor forces anything
	assign overrideMclk = txGain_ff[GAIN_OVR_BIT];
	assign autoDown = mclkLost_ff & ~overrideMclk;

	always_ff @(posedge clk) begin
		if (rst) begin
			linkBusyS1_ff <= 1'b0;
			linkBusyS2_ff <= 1'b0;
		end else begin
			linkBusyS1_ff <= linkBusy_ff;
			linkBusyS2_ff <= linkBusyS1_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pwrState_ff <= CPT_PS_DOWN;
		end else begin
			case (pwrState_ff)
				CPT_PS_DOWN: begin
					if (pwrCtrl_ff[PWR_UP_BIT] && !autoDown) begin
						pwrState_ff <= CPT_PS_UP;
					end
				end
				CPT_PS_UP: begin
					if (autoDown) begin
						pwrState_ff <= CPT_PS_DOWN;
					end else if (!pwrCtrl_ff[PWR_UP_BIT]) begin
						pwrState_ff <= CPT_PS_DRAIN;
					end
				end
				CPT_PS_DRAIN: begin
					// finish the word in flight first
					if (autoDown || !linkBusyS2_ff) begin
						pwrState_ff <= CPT_PS_DOWN;
					end
				end
				default: begin
					pwrState_ff <= CPT_PS_DOWN;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			powered <= 1'b0;
			deepPowerDown <= 1'b0;
			differentialEarphoneEn <= 1'b0;
			singleEndedEarphoneEn <= 1'b0;
			earphoneMute <= 1'b0;
			sidetoneMute <= 1'b0;
			microphoneMute <= 1'b0;
			txGainCode <= TX_GAIN_RST[3:0];
			extendedGainMode <= 1'b0;
			linearMode <= 1'b0;
			aLawMode <= 1'b0;
		end else begin
			powered <= (pwrState_ff != CPT_PS_DOWN);
			deepPowerDown <= (pwrState_ff == CPT_PS_DOWN) & txGain_ff[GAIN_OVR_BIT];
			differentialEarphoneEn <= (pwrState_ff != CPT_PS_DOWN) &
				pwrCtrl_ff[EAR_DIFF_BIT];
			singleEndedEarphoneEn <= (pwrState_ff != CPT_PS_DOWN) &
				~pwrCtrl_ff[EAR_DIFF_BIT];
			earphoneMute <= pwrCtrl_ff[EAR_MUTE_BIT];
			sidetoneMute <= pwrCtrl_ff[SIDETONE_MUTE_BIT];
			microphoneMute <= pwrCtrl_ff[MIC_MUTE_BIT];
			txGainCode <= txGain_ff[3:0];
			extendedGainMode <= ~txGain_ff[GAIN_MODE_BIT];
			linearMode <= convMode_ff[CONV_LINEAR_BIT];
			aLawMode <= convMode_ff[CONV_ALAW_BIT];
		end
	end

	// ********************************
	// link domain: pcm transmit
	// ********************************
	// link logic resets only while the bit clock runs
	logic rstL1_ff;
	logic rstL2_ff;
	logic enL1_ff;
	logic enL2_ff;
	logic reqL1_ff;
	logic reqL2_ff;
	logic reqL3_ff;
	logic [14:0] linkWord_ff;
	logic linkLinear_ff;
	logic [14:0] shift_ff;
	logic [3:0] bitsLeft_ff;
	logic lastLow_ff;
	logic linkEnable_ff;

	// registered: the two-bit state compare must not glitch into the link domain
	always_ff @(posedge clk) begin
		if (rst) begin
			linkEnable_ff <= 1'b0;
		end else begin
			linkEnable_ff <= (pwrState_ff == CPT_PS_UP);
		end
	end

	always_ff @(posedge pcmBitClock) begin
		rstL1_ff <= rst;
		rstL2_ff <= rstL1_ff;
		if (rstL2_ff) begin
			enL1_ff <= 1'b0;
			enL2_ff <= 1'b0;
			reqL1_ff <= 1'b0;
			reqL2_ff <= 1'b0;
			reqL3_ff <= 1'b0;
		end else begin
			enL1_ff <= linkEnable_ff;
			enL2_ff <= enL1_ff;
			reqL1_ff <= reqTgl_ff;
			reqL2_ff <= reqL1_ff;
			reqL3_ff <= reqL2_ff;
		end
	end

	// request toggle is stable for two link edges before the word is taken
	always_ff @(posedge pcmBitClock) begin
		if (rstL2_ff) begin
			linkWord_ff <= TX_WORD_RST;
			linkLinear_ff <= 1'b0;
			ackTgl_ff <= 1'b0;
		end else if (reqL2_ff ^ reqL3_ff) begin
			linkWord_ff <= txWord_ff;
			linkLinear_ff <= txLinear_ff;
			ackTgl_ff <= reqL2_ff;
		end
	end

	// new words start only while powered; a started word completes unless clock loss without the override floats the pin
	always_ff @(posedge pcmBitClock) begin
		if (rstL2_ff) begin
			linkBusy_ff <= 1'b0;
			shift_ff <= 15'h0000;
			bitsLeft_ff <= 4'h0;
		end else if (!linkBusy_ff && pcmFrameSync && enL2_ff) begin
			linkBusy_ff <= 1'b1;
			shift_ff <= linkLinear_ff ? linkWord_ff : {linkWord_ff[7:0], 7'h00};
			bitsLeft_ff <= linkLinear_ff ? LINEAR_LAST : COMPAND_LAST;
		end else if (linkBusy_ff && bitsLeft_ff != 4'h0) begin
			shift_ff <= {shift_ff[13:0], 1'b0};
			bitsLeft_ff <= bitsLeft_ff - 4'h1;
		end else if (linkBusy_ff && lastLow_ff) begin
			linkBusy_ff <= 1'b0;
		end
	end

	// falling edge inside the last bit ends the drive
	always_ff @(negedge pcmBitClock) begin
		if (rstL2_ff) begin
			lastLow_ff <= 1'b0;
		end else begin
			lastLow_ff <= linkBusy_ff & (bitsLeft_ff == 4'h0);
		end
	end

	assign pcmSerialOut = shift_ff[14];
	// clock loss without the override floats the pin at once, since the bit clock may be gone too
	assign pcmSerialOutEn_n = ~(linkBusy_ff & ~lastLow_ff) | autoDown;

endmodule
`default_nettype wire

// File: tb/cpt_pcm_host.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_pcm_host (
	// pcm link
	output logic pcmBitClock,
	output logic pcmFrameSync,
	input wire logic pcmSerialOut,
	input wire logic pcmSerialOutEn_n,
	// captured frame
	output logic [15:0] rxBits,
	output logic [4:0] drvCnt
);
	logic lastBit;
	initial begin
		pcmBitClock = 0;
		pcmFrameSync = 0;
		lastBit = 0;
	end
	// bit clock stands still between frames
	task automatic frame(input logic fs);
		rxBits = '0;
		drvCnt = '0;
		// sync rises apart from the previous frame's final drop
		#10 pcmFrameSync = fs;
		repeat (16) begin
			#50 pcmBitClock = 1;
			// a floating line reads as the inverse of the last bit
			#40 lastBit = pcmSerialOutEn_n ? ~lastBit : pcmSerialOut;
			drvCnt += {4'h0, !pcmSerialOutEn_n};
			rxBits = {rxBits[14:0], lastBit};
			#40 pcmBitClock = 0;
			#30 pcmFrameSync = 0;
		end
	endtask
endmodule
`default_nettype wire

// File: tb/cpt_codec_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_codec_ctrl_monitor import cpt_pkg::*; (
	// system
	input wire logic clk,
	input wire logic rst,
	// register bus
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// pins
	input wire logic masterClock,
	input wire logic pcmBitClock,
	input wire logic pcmSerialOutEn_n,
	input wire logic powered,
	input wire logic differentialEarphoneEn,
	input wire logic singleEndedEarphoneEn,
	input wire logic [3:0] txGainCode,
	input wire logic extendedGainMode
);
	localparam int LOSS_LIM = MCLK_LOSS_CYC + 8;
	logic mclkQ_ff;
	logic ovr_ff;
	logic [10:0] idle_ff;
	// silence counter saturates so it never wraps back to zero
	always_ff @(posedge clk) begin
		mclkQ_ff <= masterClock;
		if (rst || masterClock != mclkQ_ff) begin
			idle_ff <= '0;
		end else if (idle_ff != 11'h7ff) begin
			idle_ff <= idle_ff + 11'h1;
		end
	end
	// override voids the loss check
	always_ff @(posedge clk) begin
		if (rst) begin
			ovr_ff <= 1'b0;
		end else if (write && !waitrequest && address == TX_GAIN_OFS) begin
			ovr_ff <= writedata[7];
		end
	end
	property p_wait;
		@(posedge clk) disable iff (rst) (read || write) && waitrequest |=> !waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("no answer");
	property p_rdhi;
		@(posedge clk) disable iff (rst) read && !waitrequest |-> readdata[31:16] == 16'h0;
	endproperty
	a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
	property p_rgain;
		@(posedge clk) disable iff (rst) $fell(rst) |-> txGainCode == 4'hb && !extendedGainMode;
	endproperty
	a_rgain: assert property (p_rgain) else $error("gain reset");
	property p_rpwr;
		@(posedge clk) disable iff (rst) $fell(rst) |-> !powered && pcmSerialOutEn_n;
	endproperty
	a_rpwr: assert property (p_rpwr) else $error("power reset");
	property p_ear;
		@(posedge clk) disable iff (rst) differentialEarphoneEn |-> !singleEndedEarphoneEn;
	endproperty
	a_ear: assert property (p_ear) else $error("both earphones");
	property p_ext;
		@(posedge clk) disable iff (rst) extendedGainMode != txGainCode[3];
	endproperty
	a_ext: assert property (p_ext) else $error("gain range");
	property p_loss;
		@(posedge clk) disable iff (rst) idle_ff > LOSS_LIM && !ovr_ff |-> !powered && pcmSerialOutEn_n;
	endproperty
	a_loss: assert property (p_loss) else $error("clock loss");
	property p_word;
		@(posedge pcmBitClock) disable iff (rst) $fell(pcmSerialOutEn_n) |-> !pcmSerialOutEn_n[*7];
	endproperty
	a_word: assert property (p_word) else $error("word cut");
endmodule
bind cpt_codec_ctrl cpt_codec_ctrl_monitor u_mon (.clk, .rst, .address, .read, .write,
	.writedata, .readdata, .waitrequest, .masterClock, .pcmBitClock, .pcmSerialOutEn_n,
	.powered, .differentialEarphoneEn, .singleEndedEarphoneEn, .txGainCode, .extendedGainMode);
`default_nettype wire

// File: tb/test_codec_power_and_tx_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_codec_power_and_tx_control import cpt_pkg::*;;
	logic clk, rst, read, write, waitrequest, masterClock, mclkRun;
	logic [4:0] address;
	logic [31:0] writedata, readdata, q;
	logic [3:0] byteenable, txGainCode;
	logic pcmBitClock, pcmFrameSync, pcmSerialOut, pcmSerialOutEn_n, powered, deepPowerDown;
	logic differentialEarphoneEn, singleEndedEarphoneEn, microphoneMute, extendedGainMode;
	logic linearMode, aLawMode, earphoneMute, sidetoneMute;
	logic [15:0] rxBits;
	logic [4:0] drvCnt;
	int error_cnt, checks_done, cyc;
	cpt_codec_ctrl dut (.clk, .rst, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .masterClock, .pcmBitClock, .pcmFrameSync, .pcmSerialOut,
		.pcmSerialOutEn_n, .powered, .deepPowerDown, .differentialEarphoneEn,
		.singleEndedEarphoneEn, .earphoneMute, .sidetoneMute, .microphoneMute,
		.txGainCode, .extendedGainMode, .linearMode, .aLawMode);
	cpt_pcm_host host (.pcmBitClock, .pcmFrameSync, .pcmSerialOut, .pcmSerialOutEn_n,
		.rxBits, .drvCnt);
	// ****************
	// bus and compare
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		// only the bench timeout ends a wait
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0);
		q = readdata;
		chk(32'(n), 32'h2);
		write <= 0;
		read <= 0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(q, e);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	// first frame may still carry the previous word
	task automatic frames();
		host.frame(1'b1);
		host.frame(1'b1);
		@(posedge clk);
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		rd(PWR_CTRL_OFS, 32'h0);
		rd(TX_GAIN_OFS, 32'hb);
		rd(CONV_MODE_OFS, 32'h0);
		rd(TX_WORD_OFS, 32'h0);
		rd(5'h14, 32'h0);
		$display("reset done");
	endtask
	task automatic t_cfg();
		wr(TX_GAIN_OFS, 32'h05);
		wr(PWR_CTRL_OFS, 32'h42);
		chk(32'({txGainCode, extendedGainMode, microphoneMute, powered}), 32'h2e);
		rd(TX_GAIN_OFS, 32'h05);
		wr(TX_GAIN_OFS, 32'h0d);
		chk(32'({txGainCode, extendedGainMode}), 32'h1a);
		wr(PWR_CTRL_OFS, 32'h03);
		repeat (4) @(posedge clk);
		chk(32'({powered, differentialEarphoneEn, singleEndedEarphoneEn}), 32'h6);
		wr(PWR_CTRL_OFS, 32'h89);
		repeat (4) @(posedge clk);
		chk(32'({powered, differentialEarphoneEn, singleEndedEarphoneEn}), 32'h5);
		chk(32'({earphoneMute, sidetoneMute, microphoneMute}), 32'h6);
		$display("config done");
	endtask
	task automatic t_link();
		wr(CONV_MODE_OFS, 32'h1);
		wr(TX_WORD_OFS, 32'h5a3c);
		frames();
		chk(32'({rxBits[15:1], drvCnt}), {12'h0, 15'h5a3c, 5'd15});
		wr(CONV_MODE_OFS, 32'h0);
		wr(TX_WORD_OFS, 32'hc3);
		wr(TX_WORD_OFS, 32'h3c);
		rd(TX_WORD_OFS, 32'hc3);
		rd(STATUS_OFS, 32'h0b);
		frames();
		chk(32'({rxBits[15:8], drvCnt, linearMode}), {18'h0, 8'hc3, 5'd8, 1'b0});
		wr(CONV_MODE_OFS, 32'h2);
		chk(32'({aLawMode, linearMode}), 32'h2);
		$display("link done");
	endtask
	task automatic t_drain();
		wr(TX_GAIN_OFS, 32'h0b);
		fork
			host.frame(1'b1);
			begin
				repeat (20) @(posedge clk);
				wr(PWR_CTRL_OFS, 32'h0);
			end
		join
		@(posedge clk);
		chk(32'({rxBits[15:8], drvCnt}), 32'h1868);
		repeat (8) @(posedge clk);
		chk(32'({powered, deepPowerDown}), 32'h0);
		wr(TX_GAIN_OFS, 32'h8b);
		repeat (4) @(posedge clk);
		chk(32'(deepPowerDown), 32'h1);
		rd(STATUS_OFS, 32'h12);
		frames();
		chk(32'(drvCnt), 32'h0);
		$display("drain done");
	endtask
	task automatic t_mclk();
		wr(TX_GAIN_OFS, 32'h0b);
		wr(PWR_CTRL_OFS, 32'h1);
		mclkRun <= 0;
		repeat (MCLK_LOSS_CYC + 20) @(posedge clk);
		chk(32'({powered, pcmSerialOutEn_n}), 32'h1);
		wr(TX_GAIN_OFS, 32'h8b);
		repeat (4) @(posedge clk);
		chk(32'(powered), 32'h1);
		wr(PWR_CTRL_OFS, 32'h0);
		repeat (8) @(posedge clk);
		chk(32'({powered, deepPowerDown}), 32'h1);
		mclkRun <= 1;
		$display("mclk done");
	endtask
	// ****************
	// main
	// ****************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (mclkRun) begin
			masterClock <= ~masterClock;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			error_cnt++;
			complete_run();
		end
	end
	initial begin
		rst = 1;
		read = 0;
		write = 0;
		address = '0;
		writedata = '0;
		byteenable = 4'hf;
		masterClock = 0;
		mclkRun = 0;
		// link logic resets only on bit clock edges
		fork
			host.frame(1'b0);
		join_none
		repeat (20) @(posedge clk);
		rst <= 0;
		mclkRun <= 1;
		repeat (100) @(posedge clk);
		t_reset();
		t_cfg();
		t_link();
		t_drain();
		t_mclk();
		complete_run();
	end
endmodule
`default_nettype wire
